// *** inc/rof_pkg.sv ***
// package for the relay output / frequency detection block
// assumes frequencies are unsigned, 0.01 Hz per lsb
package rof_pkg;
  // ==========================================================
  // widths and reset values
  localparam int          FREQ_W          = 16;
  localparam logic [5:0]  FUNC_MAX        = 6'h2d;  // 45
  localparam logic [5:0]  RELAY_ONE_OUTPUT_RST_FUNC = 6'h1d;  // 29 trip
  localparam logic [5:0]  RELAY_TWO_OUTPUT_RST_FUNC = 6'h0e;  // 14 run
  localparam logic [15:0] SETPOINT_RST    = 16'h0bb8; // 30.00 Hz
  localparam logic [15:0] BAND_RST        = 16'h03e8; // 10.00 Hz
  // ==========================================================
  // function codes
  localparam logic [5:0]  FN_NONE  = 6'h00;
  localparam logic [5:0]  FN_FDT1  = 6'h01;
  localparam logic [5:0]  FN_FDT2  = 6'h02;
  localparam logic [5:0]  FN_FDT3  = 6'h03;
  localparam logic [5:0]  FN_FDT4  = 6'h04;
  localparam logic [5:0]  FN_RUN   = 6'h0e;

  typedef logic [FREQ_W-1:0] rof_freq_t;

  typedef struct packed {
    rof_freq_t referenceFreq;
    rof_freq_t outputFreq;
    rof_freq_t operationFreq;
    rof_freq_t maxFreq;
  } rof_freqs_t;

  typedef struct packed {
    logic runCommand;
    logic outputActive;
    logic dcBraking;
    logic accelerating;
    logic decelerating;
  } rof_drive_t;
endpackage

// *** rtl/rof_relay_output.sv ***
// relay output function selection with frequency detection
// assumes all inputs come from logic on core_clk
`timescale 1ns/100ps
// Behaviour
// [R1] relay one selector takes codes 0 to 45 and resets to 29.
// [R2] relay two selector takes codes 0 to 45 and resets to 14.
// [R3] a two-bit monitor shows the on/off state of each relay.
// [R4] code 1 energizes while |reference - output| is below half the band.
// [R5] code 2 energizes while |reference - setpoint| is below half band and the code 1 test holds.
// [R6] code 3 energizes while |output - operation| is below half the band.
// [R7] the detection setpoint resets to 30.00 Hz and is limited to 0 up to the max frequency.
// [R8] the detection band resets to 10.00 Hz and its half is used by every comparison except the code 4 acceleration test.
// [R9] setpoint and band feed the detection functions 1, 2, 3, 4 and 23; code 23 is not built here and stays off.
// [R10] code 4 turns on in acceleration at setpoint and holds in deceleration above setpoint minus half band.
// [R11] code 14 energizes while running with output voltage, and not during dc braking.
// [R12] code 0 keeps the relay off.
// [R13] comparisons run every cycle and outputs update from registered results.
module rof_relay_output (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // setting writes
  input  wire logic              relayOneFuncWrite,
  input  wire logic              relayTwoFuncWrite,
  input  wire logic [5:0]        funcWriteData,
  input  wire logic              setpointWrite,
  input  wire logic              bandWrite,
  input  wire rof_pkg::rof_freq_t settingWriteData,
  // drive state
  input  wire rof_pkg::rof_freqs_t freqs,
  input  wire rof_pkg::rof_drive_t drive,
  // settings read back
  output logic [5:0]             relay_one_function_select,
  output logic [5:0]             relay_two_function_select,
  output rof_pkg::rof_freq_t     detect_freq_setpoint,
  output rof_pkg::rof_freq_t     detect_freq_band,
  // relays
  output logic                   relay_one_output,
  output logic                   relay_two_output,
  output logic [1:0]             relay_state_monitor
);
  import rof_pkg::*;

  // ==========================================================
  // settings
  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_one_function_select <= RELAY_ONE_OUTPUT_RST_FUNC; // [R1]
    end else if (relayOneFuncWrite && funcWriteData <= FUNC_MAX) begin
      relay_one_function_select <= funcWriteData; // [R1]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_two_function_select <= RELAY_TWO_OUTPUT_RST_FUNC; // [R2]
    end else if (relayTwoFuncWrite && funcWriteData <= FUNC_MAX) begin
      relay_two_function_select <= funcWriteData; // [R2]
    end
  end

  // out-of-range setpoint is clamped rather than refused
  always_ff @(posedge core_clk) begin
    if (rst) begin
      detect_freq_setpoint <= SETPOINT_RST; // [R7]
    end else if (setpointWrite) begin
      detect_freq_setpoint <= (settingWriteData > freqs.maxFreq) ? freqs.maxFreq : settingWriteData; // [R7]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      detect_freq_band <= BAND_RST; // [R8]
    end else if (bandWrite) begin
      detect_freq_band <= settingWriteData; // [R8]
    end
  end

  // ==========================================================
  // comparisons
  function automatic rof_freq_t absDiff(input rof_freq_t a, input rof_freq_t b);
    absDiff = (a > b) ? rof_freq_t'(a - b) : rof_freq_t'(b - a);
  endfunction

  rof_freq_t halfBand;
  logic      next_refArrive;
  logic      next_setArrive;
  logic      next_rampTrack;
  logic      next_threshAcc;
  logic      next_threshDec;
  logic      reference_arrival_detect;
  logic      setpoint_arrival_detect;
  logic      ramp_tracking_detect;
  logic      directional_threshold_detect;
  logic      runDetect;
  // one extra bit so operation plus half band never overflows
  logic [FREQ_W:0] opPlusHalf;
  logic [FREQ_W:0] setpointWide;

  // half band comes from the band setting; a truncated 0.005 Hz is harmless
  assign halfBand = {1'b0, detect_freq_band[FREQ_W-1:1]}; // [R8]

  always_comb begin
    next_refArrive = absDiff(freqs.referenceFreq, freqs.outputFreq) < halfBand; // [R4] [R9]
    next_setArrive = absDiff(freqs.referenceFreq, detect_freq_setpoint) < halfBand; // [R5] [R9]
    next_rampTrack = absDiff(freqs.outputFreq, freqs.operationFreq) < halfBand; // [R6] [R9]
    next_threshAcc = freqs.operationFreq >= detect_freq_setpoint; // [R10]
    // compare op + half > setpoint instead of op > setpoint - half
    opPlusHalf     = {1'b0, freqs.operationFreq} + {1'b0, halfBand}; // [R10]
    setpointWide   = {1'b0, detect_freq_setpoint};
    next_threshDec = opPlusHalf > setpointWide; // [R10]
  end

  // registered every cycle, one flop per flag, so each compare path is a single stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reference_arrival_detect <= 1'b0;
    end else begin
      reference_arrival_detect <= next_refArrive; // [R4] [R13]
    end
  end

  // both tests must hold in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      setpoint_arrival_detect <= 1'b0;
    end else begin
      setpoint_arrival_detect <= next_setArrive && next_refArrive; // [R5] [R13]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ramp_tracking_detect <= 1'b0;
    end else begin
      ramp_tracking_detect <= next_rampTrack; // [R6] [R13]
    end
  end

  // dc braking drops the run relay even with a run command present
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runDetect <= 1'b0;
    end else begin
      runDetect <= drive.runCommand && drive.outputActive && !drive.dcBraking; // [R11]
    end
  end

  // hysteresis: decel keeps the state only above setpoint minus half band, accel sets it at setpoint
  always_ff @(posedge core_clk) begin
    if (rst) begin
      directional_threshold_detect <= 1'b0;
    end else if (drive.decelerating) begin
      directional_threshold_detect <= directional_threshold_detect && next_threshDec; // [R10]
    end else if (drive.accelerating) begin
      directional_threshold_detect <= next_threshAcc; // [R10]
    end else begin
      directional_threshold_detect <= directional_threshold_detect ? next_threshDec : next_threshAcc; // [R10]
    end
  end

  // ==========================================================
  // function select
  function automatic logic selectFunc(input logic [5:0] code, input logic fd1, input logic fd2,
                                      input logic fd3, input logic fd4, input logic run);
    case (code)
      FN_FDT1: selectFunc = fd1; // [R4]
      FN_FDT2: selectFunc = fd2; // [R5]
      FN_FDT3: selectFunc = fd3; // [R6]
      FN_FDT4: selectFunc = fd4; // [R10]
      FN_RUN:  selectFunc = run; // [R11]
      default: selectFunc = 1'b0; // [R12]
    endcase
  endfunction

  // one decode per relay, shared by contact and monitor so the two never disagree
  logic next_relayOne;
  logic next_relayTwo;

  // code 23 and the other codes are not built here and stay off
  always_comb begin
    next_relayOne = selectFunc(relay_one_function_select,
                               reference_arrival_detect,
                               setpoint_arrival_detect,
                               ramp_tracking_detect,
                               directional_threshold_detect,
                               runDetect); // [R13]
    next_relayTwo = selectFunc(relay_two_function_select,
                               reference_arrival_detect,
                               setpoint_arrival_detect,
                               ramp_tracking_detect,
                               directional_threshold_detect,
                               runDetect); // [R13]
  end

  // ==========================================================
  // relay outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_one_output <= 1'b0;
    end else begin
      relay_one_output <= next_relayOne; // [R13]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_two_output <= 1'b0;
    end else begin
      relay_two_output <= next_relayTwo; // [R13]
    end
  end

  // monitor is its own flop so the output stays registered, at the cost of one duplicate bit per relay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_state_monitor <= 2'h0;
    end else begin
      relay_state_monitor <= {next_relayTwo, next_relayOne}; // [R3]
    end
  end
endmodule // rof_relay_output

// *** testbench/rof_relay_load.sv ***
// load model: outside equipment on the two relay contacts
// assumes coils come straight from the relay outputs
`timescale 1ns/100ps
module rof_relay_load (
  input  wire logic       core_clk, rst,
  input  wire logic [1:0] coil,
  output logic [1:0]      contact);
  // contacts lag the coils by a clock, open during reset
  always_ff @(posedge core_clk) contact <= rst ? 2'b00 : coil;
endmodule // rof_relay_load

// *** testbench/rof_relay_asserts.sv ***
// assertions on the relay block ports
// bound to rof_relay_output from tb_top
`timescale 1ns/100ps
module rof_relay_asserts import rof_pkg::*; (
  input wire logic       core_clk, rst, relayOneFuncWrite, setpointWrite, bandWrite,
  input wire logic [5:0] funcWriteData, relay_one_function_select, relay_two_function_select,
  input wire rof_freq_t  settingWriteData, detect_freq_setpoint, detect_freq_band,
  input wire rof_freqs_t freqs,
  input wire rof_drive_t drive,
  input wire logic       relay_one_output, relay_two_output,
  input wire logic [1:0] relay_state_monitor);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_mon; relay_state_monitor == {relay_two_output, relay_one_output}; endproperty
  a_mon: assert property (p_mon) else $error("monitor bits");
  property p_rs; $past(rst) |-> relay_one_function_select == 6'h1d && relay_two_function_select == 6'h0e; endproperty
  a_rs: assert property (p_rs) else $error("selector reset");
  property p_rv; $past(rst) |-> detect_freq_setpoint == 16'h0bb8 && detect_freq_band == 16'h03e8; endproperty
  a_rv: assert property (p_rv) else $error("setting reset");
  property p_wr; relayOneFuncWrite && funcWriteData <= 6'h2d |=> relay_one_function_select == $past(funcWriteData);
  endproperty
  a_wr: assert property (p_wr) else $error("selector write");
  property p_sp; setpointWrite |=> detect_freq_setpoint == ($past(settingWriteData) > $past(freqs.maxFreq) ?
    $past(freqs.maxFreq) : $past(settingWriteData)); endproperty
  a_sp: assert property (p_sp) else $error("setpoint clamp");
  property p_bd; bandWrite |=> detect_freq_band == $past(settingWriteData); endproperty
  a_bd: assert property (p_bd) else $error("band write");
  property p_off; (relay_one_function_select == 6'h00)[*2] |=> !relay_one_output; endproperty
  a_off: assert property (p_off) else $error("relay on at none");
  property p_run; (relay_two_function_select == 6'h0e && drive.runCommand && drive.outputActive &&
    !drive.dcBraking)[*3] |=> relay_two_output; endproperty
  a_run: assert property (p_run) else $error("run relay");
  property p_dec; (relay_one_function_select == 6'h04 && drive.decelerating)[*2] |=> !$rose(relay_one_output);
  endproperty
  a_dec: assert property (p_dec) else $error("threshold relay rose in deceleration");
endmodule // rof_relay_asserts

// *** testbench/tb_top.sv ***
// bench: random steps through function codes 0, 1, 2, 3, 4, 14, 23, 29 and 46
// assumes rof_pkg, checker and load model compiled first
`timescale 1ns/100ps
module tb_top;
  import rof_pkg::*;
  logic        core_clk, rst, w1, w2, spW, bdW, r1, r2;
  logic [5:0]  fd, s1, s2, o1, o2;
  logic [1:0]  mon, ct;
  rof_freq_t   wd, sp, bd, osp, obd;
  rof_freqs_t  fq;
  rof_drive_t  dv;
  logic [31:0] lf = 32'h09e2f31d;
  logic [47:0] q[$];
  logic [5:0]  codes[9] = '{0, 1, 2, 3, 4, 14, 23, 29, 46};
  int          n_errors, total_checks;
  event        look;
  rof_relay_output u_rof_relay_output(.core_clk, .rst, .relayOneFuncWrite(w1), .relayTwoFuncWrite(w2),
    .funcWriteData(fd), .setpointWrite(spW), .bandWrite(bdW), .settingWriteData(wd), .freqs(fq), .drive(dv),
    .relay_one_function_select(o1), .relay_two_function_select(o2), .detect_freq_setpoint(osp),
    .detect_freq_band(obd), .relay_one_output(r1), .relay_two_output(r2), .relay_state_monitor(mon));
  rof_relay_load u_rof_relay_load(.core_clk, .rst, .coil({r2, r1}), .contact(ct));
  // ==========================================
  // helpers
  function logic [31:0] lfsrStep(logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
  function rof_freq_t ad(rof_freq_t x, y); return x > y ? x - y : y - x; endfunction
  // code 4 is only judged while accelerating
  function logic rel(logic [5:0] c);
    case (c)
      1: return ad(fq.referenceFreq, fq.outputFreq) < bd / 2;
      2: return ad(fq.referenceFreq, fq.outputFreq) < bd / 2 && ad(fq.referenceFreq, sp) < bd / 2;
      3: return ad(fq.outputFreq, fq.operationFreq) < bd / 2;
      4: return fq.operationFreq >= sp;
      14: return dv.runCommand && dv.outputActive && !dv.dcBraking;
      default: return 1'b0;
    endcase
  endfunction
  // back-to-back writes, then hold so the registered compare settles
  task step(logic [5:0] c);
    @(negedge core_clk);
    lf = lfsrStep(lf);
    fq = {4'h0, lf[11:0], 16'h0000, 16'h0000, 16'h1770};
    fq.outputFreq = fq.referenceFreq + lf[21:12];
    fq.operationFreq = fq.outputFreq - lf[31:22];
    dv = {lf[15:13], 2'b10};
    lf = lfsrStep(lf);
    {w1, w2, spW, fd, wd} = {3'b111, c, fq.referenceFreq + lf[10:0]};
    if (c <= 6'h2d) {s1, s2} = {c, c};
    sp = wd > fq.maxFreq ? fq.maxFreq : wd;
    @(negedge core_clk);
    {w1, w2, spW, bdW, wd} = {4'b0001, 5'h00, lf[26:16]};
    bd = wd;
    @(negedge core_clk);
    bdW = 0;
    repeat (3) @(negedge core_clk);
    q.push_back({s1, s2, sp, bd, {2{rel(s2), rel(s1)}}});
    -> look;
  endtask
  // change only the operation frequency and drive state, then let flags, relays and contacts settle
  task thresh(rof_freq_t op, rof_drive_t d, logic on);
    @(negedge core_clk);
    fq.operationFreq = op;
    dv = d;
    repeat (4) @(negedge core_clk);
    q.push_back({s1, s2, sp, bd, {4{on}}});
    -> look;
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // processes
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial forever begin
    @(look);
    total_checks++;
    if (q.pop_front() !== {o1, o2, osp, obd, mon, ct}) begin
      n_errors++;
      $display("Error at %0t: outputs differ", $time);
    end
  end
  initial begin
    {rst, w1, w2, spW, bdW, fd, wd, fq, dv} = '1;
    {w1, w2, spW, bdW} = 4'h0;
    {s1, s2, sp, bd} = {6'h1d, 6'h0e, 16'h0bb8, 16'h03e8};
    repeat (12) @(negedge core_clk);
    rst = 0;
    q.push_back({s1, s2, sp, bd, 4'h0});
    -> look;
    $display("reset test done");
    foreach (codes[i]) repeat (8) step(codes[i]);
    @(negedge core_clk);
    $display("random test done");
    // code 4 hysteresis: set at setpoint in acceleration, held in deceleration above setpoint minus half band
    {w1, w2, spW, fd, wd} = {3'b111, 6'h04, 16'h0bb8};
    fq.operationFreq = 16'h0bb8;
    dv = 5'b11010;
    {s1, s2, sp, bd} = {6'h04, 6'h04, 16'h0bb8, 16'h03e8};
    @(negedge core_clk);
    {w1, w2, spW, bdW, wd} = {4'b0001, 16'h03e8};
    @(negedge core_clk);
    bdW = 0;
    thresh(16'h0bb8, 5'b11010, 1'b1);
    thresh(16'h0a28, 5'b11001, 1'b1);
    thresh(16'h0960, 5'b11001, 1'b0);
    thresh(16'h0bb8, 5'b11001, 1'b0);
    $display("threshold test done");
    conclude;
  end
  initial begin
    #50000;
    n_errors++;
    conclude;
  end
endmodule // tb_top
bind rof_relay_output rof_relay_asserts u_rof_relay_asserts(.*);
